// ---- core/dcc_consts.svh ----
// Register offsets, field positions and reset values of the dual comparator control block.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define DCC_IDX_C1_CTRL     12'h80C
`define DCC_IDX_C1_EDGE     12'h80D
`define DCC_IDX_C1_MINUS    12'h80E
`define DCC_IDX_C1_PLUS     12'h80F
`define DCC_IDX_C2_CTRL     12'h810
`define DCC_IDX_C2_EDGE     12'h811
`define DCC_IDX_C2_MINUS    12'h812
`define DCC_IDX_C2_PLUS     12'h813
`define DCC_IDX_MIRROR      12'h81F
`define DCC_IDX_IRQ_STATUS  12'h820
`define DCC_IDX_IRQ_MASK    12'h821

// ============================================================
// Control register fields
`define DCC_CTRL_ENABLE     7
`define DCC_CTRL_RESULT     6
`define DCC_CTRL_INVERT     4
`define DCC_CTRL_HYST       1
`define DCC_CTRL_LOCK       0
`define DCC_CTRL_WMASK      8'h93
`define DCC_EDGE_RISE       1
`define DCC_EDGE_FALL       0
`define DCC_EDGE_WMASK      8'h03
`define DCC_SEL_WMASK       8'h07
`define DCC_RESET_BYTE      8'h00

// ============================================================
// Input selector codes
`define DCC_MINUS_NC_LO     3'h4
`define DCC_MINUS_NC_HI     3'h5
`define DCC_SEL_REFBUF2     3'h6
`define DCC_SEL_GROUND      3'h7
`define DCC_PLUS_CONVERTER  3'h4

// ============================================================
// Analog source one-hot positions
`define DCC_SRC_PIN0        0
`define DCC_SRC_PIN1        1
`define DCC_SRC_PIN2        2
`define DCC_SRC_PIN3        3
`define DCC_SRC_CONVERTER   4
`define DCC_SRC_REFBUF2     5
`define DCC_SRC_GROUND      6
`define DCC_SRC_COUNT       7

`endif

// ---- core/dcc_pkg.sv ----
// Types shared by the dual comparator control block.
package dcc_pkg;
  typedef logic [7:0] dcc_byte_t;
  typedef logic [6:0] dcc_route_t;
endpackage

// ---- core/dcc_unit_if.sv ----
// Interface between the top and one comparator unit.
`timescale 1ns/10ps
`default_nettype none
interface dcc_unit_if;
  logic        enable;
  logic        invert;
  logic        lock;
  logic [1:0]  edge_en;
  logic        raw;
  logic        tclk_fall;
  logic        result;
  logic        edge_evt;
  modport top  (output enable, output invert, output lock, output edge_en, output raw, output tclk_fall,
                input result, input edge_evt);
  modport unit (input enable, input invert, input lock, input edge_en, input raw, input tclk_fall,
                output result, output edge_evt);
endinterface
`default_nettype wire

// ---- core/dcc_unit.sv ----
// One comparator unit: polarity, timer lock and edge detection.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_unit (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Unit signals
  dcc_unit_if.unit  u
);
  logic raw_meta;
  logic raw_sync;
  logic locked;
  logic prev_out;
  logic inv_out;
  logic next_result;

  // ============================================================
  // Polarity and timer lock
  assign inv_out     = raw_sync ^ u.invert;                    // [R8]
  assign next_result = u.lock ? locked : inv_out;              // [R2] [R3]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_meta <= 1'b0;
      raw_sync <= 1'b0;
      locked   <= 1'b0;
      prev_out <= 1'b0;
    end else begin
      raw_meta <= u.raw;
      raw_sync <= raw_meta;
      if (u.tclk_fall) begin
        locked <= inv_out;                                     // [R2]
      end
      prev_out <= next_result;
    end
  end

  assign u.result = prev_out;
  // A polarity change alters inv_out, so it counts as an edge too.
  assign u.edge_evt = (u.edge_en[`DCC_EDGE_RISE] & ~prev_out & next_result)   // [R4] [R8]
                    | (u.edge_en[`DCC_EDGE_FALL] & prev_out & ~next_result);  // [R5]

  // ============================================================
  // Checks
  a_lock_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (u.lock && !u.tclk_fall && $stable(u.lock)) |=> $stable(locked)) else $error("locked value moved"); // [R2]
  a_rise_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    (!u.edge_en[`DCC_EDGE_RISE] && !prev_out && next_result) |-> !u.edge_evt)
    else $error("masked rise flagged"); // [R4]
  a_fall_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    (!u.edge_en[`DCC_EDGE_FALL] && prev_out && !next_result) |-> !u.edge_evt)
    else $error("masked fall flagged"); // [R5]
  a_direct_path: assert property (@(posedge hclk) disable iff (!hresetn)
    !u.lock |=> (u.result == $past(raw_sync ^ u.invert))) else $error("direct path wrong"); // [R3]
endmodule
`default_nettype wire

// ---- core/dcc_top.sv ----
// Top of the dual comparator control block with its AHB-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_consts.svh"
// What this block does
// R1 - Hysteresis bit turns comparator hysteresis on
// R2 - Lock bit resamples output on timer falls
// R3 - Lock clear passes result straight through
// R4 - Rise enable sets flag on rising result
// R5 - Fall enable sets flag on falling result
// R6 - Minus selector routes pins, reference, ground
// R7 - Plus selector routes pins, converter, reference, ground
// R8 - Invert bit inverts result, change is edge
// R9 - Software clears flag before next edge
// R10 - Disabled unit disconnects all its inputs
// R11 - Mirror register holds both unit results
module dcc_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [15:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog comparator cores
  input  wire logic        unit1_raw,
  input  wire logic        unit2_raw,
  output logic             unit1_hysteresis,
  output logic             unit2_hysteresis,
  output logic [6:0]       unit1_minus_route,
  output logic [6:0]       unit1_plus_route,
  output logic [6:0]       unit2_minus_route,
  output logic [6:0]       unit2_plus_route,
  // Timer one clock source and results
  input  wire logic        timer_one_clk,
  output logic             unit1_result,
  output logic             unit2_result,
  // Interrupt
  output logic             irq
);
  dcc_pkg::dcc_byte_t ctrl     [2];
  dcc_pkg::dcc_byte_t edge_en  [2];
  dcc_pkg::dcc_byte_t minus_sel[2];
  dcc_pkg::dcc_byte_t plus_sel [2];
  logic [1:0]         irq_status;
  logic [1:0]         irq_mask;
  logic [1:0]         unit_result;
  logic [1:0]         unit_edge;
  logic               tclk_meta;
  logic               tclk_sync;
  logic               tclk_prev;
  logic               tclk_fall;
  logic               wr_pend;
  logic [11:0]        wr_idx;
  logic               rd_pend;
  logic [11:0]        rd_idx;

  // ============================================================
  // Timer clock falling-edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tclk_meta <= 1'b0;
      tclk_sync <= 1'b0;
      tclk_prev <= 1'b0;
    end else begin
      tclk_meta <= timer_one_clk;
      tclk_sync <= tclk_meta;
      tclk_prev <= tclk_sync;
    end
  end
  assign tclk_fall = tclk_prev & ~tclk_sync;                   // [R2]

  // ============================================================
  // Units
  dcc_unit_if uif[2] ();
  logic [1:0] raw_in;
  assign raw_in = {unit2_raw, unit1_raw};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_unit
      assign uif[g].enable    = ctrl[g][`DCC_CTRL_ENABLE];
      assign uif[g].invert    = ctrl[g][`DCC_CTRL_INVERT];
      assign uif[g].lock      = ctrl[g][`DCC_CTRL_LOCK];
      assign uif[g].edge_en   = edge_en[g][1:0];
      assign uif[g].raw       = raw_in[g];
      assign uif[g].tclk_fall = tclk_fall;
      assign unit_result[g]   = uif[g].result;
      assign unit_edge[g]     = uif[g].edge_evt;
      dcc_unit u_unit (
        .hclk    (hclk),
        .hresetn (hresetn),
        .u       (uif[g])
      );
    end
  endgenerate

  // ============================================================
  // Input routing
  function automatic dcc_pkg::dcc_route_t minus_route(input logic en, input logic [2:0] sel);
    dcc_pkg::dcc_route_t r;
    r = '0;
    if (en) begin                                              // [R10]
      if (sel == `DCC_SEL_GROUND) begin
        r[`DCC_SRC_GROUND] = 1'b1;                             // [R6]
      end else if (sel == `DCC_SEL_REFBUF2) begin
        r[`DCC_SRC_REFBUF2] = 1'b1;                            // [R6]
      end else if (sel != `DCC_MINUS_NC_LO && sel != `DCC_MINUS_NC_HI) begin
        r[sel[1:0]] = 1'b1;                                    // [R6]
      end
    end
    return r;
  endfunction

  function automatic dcc_pkg::dcc_route_t plus_route(input logic en, input logic [2:0] sel);
    dcc_pkg::dcc_route_t r;
    r = '0;
    if (en) begin                                              // [R10]
      if (sel == `DCC_SEL_GROUND) begin
        r[`DCC_SRC_GROUND] = 1'b1;                             // [R7]
      end else if (sel == `DCC_SEL_REFBUF2) begin
        r[`DCC_SRC_REFBUF2] = 1'b1;                            // [R7]
      end else if (sel == `DCC_PLUS_CONVERTER) begin
        r[`DCC_SRC_CONVERTER] = 1'b1;                          // [R7]
      end else if (sel[2:1] == 2'h0) begin
        r[sel[0]] = 1'b1;                                      // [R7]
      end
    end
    return r;
  endfunction

  dcc_pkg::dcc_route_t next_minus[2];
  dcc_pkg::dcc_route_t next_plus [2];
  assign next_minus[0] = minus_route(ctrl[0][`DCC_CTRL_ENABLE], minus_sel[0][2:0]);
  assign next_minus[1] = minus_route(ctrl[1][`DCC_CTRL_ENABLE], minus_sel[1][2:0]);
  assign next_plus[0]  = plus_route(ctrl[0][`DCC_CTRL_ENABLE], plus_sel[0][2:0]);
  assign next_plus[1]  = plus_route(ctrl[1][`DCC_CTRL_ENABLE], plus_sel[1][2:0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit1_minus_route <= '0;
      unit1_plus_route  <= '0;
      unit2_minus_route <= '0;
      unit2_plus_route  <= '0;
      unit1_hysteresis  <= 1'b0;
      unit2_hysteresis  <= 1'b0;
      unit1_result      <= 1'b0;
      unit2_result      <= 1'b0;
      irq               <= 1'b0;
    end else begin
      unit1_minus_route <= next_minus[0];
      unit1_plus_route  <= next_plus[0];
      unit2_minus_route <= next_minus[1];
      unit2_plus_route  <= next_plus[1];
      unit1_hysteresis  <= ctrl[0][`DCC_CTRL_HYST];            // [R1]
      unit2_hysteresis  <= ctrl[1][`DCC_CTRL_HYST];            // [R1]
      unit1_result      <= unit_result[0];
      unit2_result      <= unit_result[1];
      irq               <= |(irq_status & irq_mask);
    end
  end

  // ============================================================
  // AHB-Lite slave: zero wait states, writes land in the data phase
  logic        addr_ok;
  logic [11:0] a_idx;
  logic [7:0]  wbyte;
  assign addr_ok = hsel & hready & htrans[1];
  assign a_idx   = haddr[13:2];
  assign wbyte   = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_idx  <= '0;
      rd_idx  <= '0;
    end else begin
      wr_pend <= addr_ok & hwrite;
      rd_pend <= addr_ok & ~hwrite;
      if (addr_ok) begin
        wr_idx <= a_idx;
        rd_idx <= a_idx;
      end
    end
  end

  logic [1:0] clr_w1;
  assign clr_w1 = (wr_pend && wr_idx == `DCC_IDX_IRQ_STATUS) ? wbyte[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i]      <= `DCC_RESET_BYTE;
        edge_en[i]   <= `DCC_RESET_BYTE;
        minus_sel[i] <= `DCC_RESET_BYTE;
        plus_sel[i]  <= `DCC_RESET_BYTE;
      end
      irq_mask   <= 2'h0;
      irq_status <= 2'h0;
    end else begin
      if (wr_pend) begin
        for (int i = 0; i < 2; i++) begin
          if (wr_idx == `DCC_IDX_C1_CTRL + 12'(4 * i))  ctrl[i]      <= wbyte & `DCC_CTRL_WMASK;
          if (wr_idx == `DCC_IDX_C1_EDGE + 12'(4 * i))  edge_en[i]   <= wbyte & `DCC_EDGE_WMASK;
          if (wr_idx == `DCC_IDX_C1_MINUS + 12'(4 * i)) minus_sel[i] <= wbyte & `DCC_SEL_WMASK;
          if (wr_idx == `DCC_IDX_C1_PLUS + 12'(4 * i))  plus_sel[i]  <= wbyte & `DCC_SEL_WMASK;
        end
        if (wr_idx == `DCC_IDX_IRQ_MASK) irq_mask <= wbyte[1:0];
      end
      // A new edge wins over a same-cycle clear.
      irq_status <= (irq_status & ~clr_w1) | unit_edge;       // [R4] [R5] [R9]
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (rd_idx == `DCC_IDX_C1_CTRL + 12'(4 * i)) begin
        rd_byte = ctrl[i];
        rd_byte[`DCC_CTRL_RESULT] = unit_result[i];
      end
      if (rd_idx == `DCC_IDX_C1_EDGE + 12'(4 * i))  rd_byte = edge_en[i];
      if (rd_idx == `DCC_IDX_C1_MINUS + 12'(4 * i)) rd_byte = minus_sel[i];
      if (rd_idx == `DCC_IDX_C1_PLUS + 12'(4 * i))  rd_byte = plus_sel[i];
    end
    if (rd_idx == `DCC_IDX_MIRROR)     rd_byte = {6'h00, unit_result};   // [R11]
    if (rd_idx == `DCC_IDX_IRQ_STATUS) rd_byte = {6'h00, irq_status};
    if (rd_idx == `DCC_IDX_IRQ_MASK)   rd_byte = {6'h00, irq_mask};
  end

  // Read data is combinational off registered state so it lands in the data phase.
  assign hrdata    = rd_pend ? {24'h000000, rd_byte} : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ============================================================
  // Checks
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 irq == $past(|(irq_status & irq_mask))) else $error("irq not tracking"); // [R9]
  a_disabled_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[0][`DCC_CTRL_ENABLE] |=> (unit1_minus_route == '0 && unit1_plus_route == '0))
    else $error("disabled unit routed"); // [R10]
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_status[0] && !clr_w1[0]) |=> irq_status[0]) else $error("flag lost"); // [R9]
  a_hyst_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 unit2_hysteresis == $past(ctrl[1][`DCC_CTRL_HYST])) else $error("hysteresis wrong"); // [R1]
endmodule
`default_nettype wire

// ---- verification/dcc_core_model.sv ----
// Behavioural model of one analog comparator core with its selectable sources.
`timescale 1ns/10ps
`default_nettype none
module dcc_core_model (
  // Routing from the block
  input  wire logic [6:0]  minus_route,
  input  wire logic [6:0]  plus_route,
  input  wire logic        hysteresis,
  // Source levels, one byte per source position
  input  wire logic [55:0] levels,
  // Comparator decision
  output logic             raw
);
  int p;
  int m;
  // ==========================================================
  // Source selection
  function automatic int pick(input logic [6:0] r, input logic [55:0] lv);
    int v;
    v = -1;
    for (int i = 0; i < 7; i++) begin
      if (r[i]) begin
        v = int'(lv[i*8 +: 8]);
      end
    end
    return v;
  endfunction
  assign p = pick(plus_route, levels);
  assign m = pick(minus_route, levels);
  // An open input gives the core nothing to compare, so it rests low.
  // Inside the hysteresis band the last decision is kept.
  always @(p or m or hysteresis) begin
    if (p < 0 || m < 0) begin
      raw = 1'b0;
    end else if (!hysteresis || p - m > 8 || m - p > 8) begin
      raw = (p > m);
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking testbench of the dual comparator control block.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_consts.svh"
module tb;
  typedef struct {logic [11:0] idx; logic [31:0] exp;} dcc_row_s;
  localparam logic [6:0] MR [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h00, 7'h00, 7'h20, 7'h40};
  localparam logic [6:0] PR [8] = '{7'h01, 7'h02, 7'h00, 7'h00, 7'h10, 7'h00, 7'h20, 7'h40};
  dcc_row_s rows [9] = '{'{`DCC_IDX_C1_EDGE, 32'h3}, '{`DCC_IDX_C1_MINUS, 32'h7},
    '{`DCC_IDX_C1_PLUS, 32'h7}, '{`DCC_IDX_C2_EDGE, 32'h3}, '{`DCC_IDX_C2_MINUS, 32'h7},
    '{`DCC_IDX_C2_PLUS, 32'h7}, '{`DCC_IDX_IRQ_MASK, 32'h3}, '{`DCC_IDX_MIRROR, 32'h0},
    '{12'h900, 32'h0}};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        u1_raw;
  logic        u2_raw;
  logic        u1_hys;
  logic        u2_hys;
  logic [6:0]  u1_minus;
  logic [6:0]  u1_plus;
  logic [6:0]  u2_minus;
  logic [6:0]  u2_plus;
  logic        timer_one_clk;
  logic        unit1_result;
  logic        unit2_result;
  logic        irq;
  logic [7:0]  lvl [7];
  logic [55:0] levels;
  int          fail_count;
  int          total_checks;
  assign hready = hreadyout;
  assign levels = {lvl[6], lvl[5], lvl[4], lvl[3], lvl[2], lvl[1], lvl[0]};
  dcc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .unit1_raw(u1_raw), .unit2_raw(u2_raw),
    .unit1_hysteresis(u1_hys), .unit2_hysteresis(u2_hys), .unit1_minus_route(u1_minus),
    .unit1_plus_route(u1_plus), .unit2_minus_route(u2_minus), .unit2_plus_route(u2_plus),
    .timer_one_clk(timer_one_clk), .unit1_result(unit1_result), .unit2_result(unit2_result), .irq(irq));
  dcc_core_model core1_u (.minus_route(u1_minus), .plus_route(u1_plus), .hysteresis(u1_hys),
    .levels(levels), .raw(u1_raw));
  dcc_core_model core2_u (.minus_route(u2_minus), .plus_route(u2_plus), .hysteresis(u2_hys),
    .levels(levels), .raw(u2_raw));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ==========================================================
  // Shared tasks
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus_wait();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask
  // The data phase drives an idle address phase, so the next transfer's address phase never overlaps it.
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    bus_wait();
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input string n);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    check(n, q, exp);
  endtask
  task automatic settle();
    repeat (8) @(posedge hclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 16'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timer_one_clk = 1'b1;
    lvl = '{8'h40, 8'h80, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("irq after reset", 32'(irq), 32'h0);
    check("bus response", {30'h0, hreadyout, hresp}, 32'h2);
    for (int i = 0; i < 9; i++) begin
      rd(rows[i].idx, 32'h0, "reset value");
      wr(rows[i].idx, 32'hFF);
      rd(rows[i].idx, rows[i].exp, "written value");
    end
    wr(`DCC_IDX_C1_CTRL, 32'h80);
    for (int c = 0; c < 8; c++) begin
      wr(`DCC_IDX_C1_MINUS, 32'(c));
      wr(`DCC_IDX_C1_PLUS, 32'(c));
      settle();
      check("minus route", 32'(u1_minus), 32'(MR[c]));
      check("plus route", 32'(u1_plus), 32'(PR[c]));
    end
    wr(`DCC_IDX_C1_CTRL, 32'h02);
    settle();
    check("routes disabled", {u1_minus, u1_plus}, 32'h0);
    check("hysteresis on", 32'(u1_hys), 32'h1);
    wr(`DCC_IDX_C1_CTRL, 32'h82);
    wr(`DCC_IDX_C1_MINUS, 32'h1);
    wr(`DCC_IDX_C1_CTRL, 32'h82);
    wr(`DCC_IDX_C1_PLUS, 32'h0);
    wr(`DCC_IDX_C1_EDGE, 32'h2);
    wr(`DCC_IDX_IRQ_MASK, 32'h1);
    settle();
    check("hysteresis on", 32'(u1_hys), 32'h1);
    wr(`DCC_IDX_C1_CTRL, 32'h80);
    wr(`DCC_IDX_IRQ_STATUS, 32'h3);
    settle();
    check("hysteresis off", 32'(u1_hys), 32'h0);
    check("irq cleared", 32'(irq), 32'h0);
    lvl[0] <= 8'hC0;
    settle();
    check("direct result", 32'(unit1_result), 32'h1);
    check("irq on rise", 32'(irq), 32'h1);
    rd(`DCC_IDX_IRQ_STATUS, 32'h1, "rise flag");
    wr(`DCC_IDX_IRQ_STATUS, 32'h1);
    lvl[0] <= 8'h40;
    settle();
    rd(`DCC_IDX_IRQ_STATUS, 32'h0, "fall ignored");
    wr(`DCC_IDX_C1_EDGE, 32'h1);
    lvl[0] <= 8'hC0;
    settle();
    rd(`DCC_IDX_IRQ_STATUS, 32'h0, "rise ignored");
    lvl[0] <= 8'h40;
    wr(`DCC_IDX_IRQ_MASK, 32'h0);
    settle();
    rd(`DCC_IDX_IRQ_STATUS, 32'h1, "fall flag");
    check("irq masked", 32'(irq), 32'h0);
    wr(`DCC_IDX_IRQ_STATUS, 32'h1);
    wr(`DCC_IDX_C1_EDGE, 32'h3);
    wr(`DCC_IDX_C1_CTRL, 32'h90);
    settle();
    check("inverted result", 32'(unit1_result), 32'h1);
    rd(`DCC_IDX_IRQ_STATUS, 32'h1, "invert edge");
    rd(`DCC_IDX_C1_CTRL, 32'hD0, "control readback");
    wr(`DCC_IDX_C1_CTRL, 32'h80);
    wr(`DCC_IDX_C2_CTRL, 32'h82);
    wr(`DCC_IDX_C2_PLUS, 32'h4);
    wr(`DCC_IDX_C2_MINUS, 32'h7);
    lvl[0] <= 8'hC0;
    settle();
    check("unit two result", 32'(unit2_result), 32'h1);
    check("unit two hysteresis", 32'(u2_hys), 32'h1);
    check("unit two plus route", 32'(u2_plus), 32'h10);
    check("unit two minus route", 32'(u2_minus), 32'h40);
    rd(`DCC_IDX_MIRROR, 32'h3, "mirror both");
    lvl[0] <= 8'h40;
    settle();
    rd(`DCC_IDX_MIRROR, 32'h2, "mirror unit two");
    wr(`DCC_IDX_C1_CTRL, 32'h81);
    lvl[0] <= 8'hC0;
    settle();
    check("locked hold", 32'(unit1_result), 32'h0);
    timer_one_clk <= 1'b0;
    settle();
    check("locked update", 32'(unit1_result), 32'h1);
    timer_one_clk <= 1'b1;
    lvl[0] <= 8'h40;
    settle();
    check("locked hold low", 32'(unit1_result), 32'h1);
    wr(`DCC_IDX_C1_CTRL, 32'h80);
    settle();
    check("unlocked result", 32'(unit1_result), 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
